/* File: thermal_supervisor_map.vh */
// Constants for the connector thermal supervisor: limits, timing and codes.
// Assumes temperatures arrive as unsigned codes in units of 0.5 degC.
`ifndef THERMAL_SUPERVISOR_MAP_VH
`define THERMAL_SUPERVISOR_MAP_VH

`define TS_CLK_HZ          20000000
`define TS_TEMP_W          10
// Contact limit 90 degC at 0.5 degC per code step.
`define TS_LIMIT_DEGC      90
`define TS_LIMIT_CODE      10'h0B4
// Plausible window of a sensor code.
`define TS_PLAUS_MIN       10'h000
`define TS_PLAUS_MAX       10'h190
// Shutdown deadline 9 s; the block reacts well inside it after a short filter.
`define TS_DEADLINE_S      9
`define TS_FILTER_MS       100
`define TS_FILTER_CYC      (`TS_CLK_HZ / 1000 * `TS_FILTER_MS)
// A sensor with no new sample for this long counts as silent.
`define TS_SILENT_MS       500
`define TS_SILENT_CYC      (`TS_CLK_HZ / 1000 * `TS_SILENT_MS)
`define TS_LOCK_COUNT      2'h3
`define TS_CUR_W           10

`endif

/* File: fault_filter.v */
// Fault persistence filter: asserts its output once the input fault holds for a count.
// Assumes the fault input is synchronous to clk_sys_i.
`timescale 1ns/1ps
module fault_filter #(
	parameter LIMIT = 2000000
) (
	input  wire clk_sys_i,
	input  wire rst_i,
	input  wire fault_i,
	output reg  hit_o
);
	reg [31:0] cnt_q;

	always @(posedge clk_sys_i) begin
		if (rst_i || !fault_i) begin
			cnt_q <= 32'h0;
			hit_o <= 1'b0;
		end else if (cnt_q >= LIMIT - 1) begin
			hit_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
endmodule // fault_filter

/* File: connector_thermal_supervisor.v */
// Connector thermal supervisor: watches both contact sensors and the cooling loop.
// Assumes sensors, cooling and service inputs are asynchronous pins; session inputs
// come from the charging controller on clk_sys_i.
//
// Notes on behaviour
// R1: Contact temperature is held at or below 90 degC while power is supplied.
// R2: The plus and minus contact readings are evaluated each on their own.
// R3: A cooling hardware failure stops supply or derates to the no-cooling current.
// R4: The derated current limit is reported to the vehicle over the link.
// R5: Contact readings are checked every cycle during the whole session.
// R6: A contact above 90 degC starts an error shutdown well within 9 s.
// R7: Three overtemperature shutdowns in a row lock out new sessions until service.
// R8: Sensor plausibility is checked before each session starts.
// R9: A failed pre-session check limits output to the no-cooling current.
// R10: A failed pre-session check blocks new sessions until service.
// R11: A silent or implausible sensor during charging starts an error shutdown within 9 s.
// R12: Coolant flow, pressure, temperature and level are supervised for a first fault.
// R13: A clean session end clears the count, and service clears both lockouts.
// R14: Separate status flags show overtemperature, sensor fault, cooling and lockout.
`timescale 1ns/1ps
`include "thermal_supervisor_map.vh"
module connector_thermal_supervisor #(
	parameter [`TS_CUR_W-1:0] NOCOOL_CUR   = 10'h064,
	parameter [`TS_CUR_W-1:0] RATED_CUR    = 10'h1F4,
	parameter                 HAS_NOCOOL   = 1,
	parameter                 FILTER_CYC   = `TS_FILTER_CYC,
	parameter                 SILENT_CYC   = `TS_SILENT_CYC
) (
	input  wire                 clk_sys_i,
	input  wire                 rst_i,
	input  wire [`TS_TEMP_W-1:0] temp_pos_i,
	input  wire                 temp_pos_valid_i,
	input  wire [`TS_TEMP_W-1:0] temp_neg_i,
	input  wire                 temp_neg_valid_i,
	input  wire                 cool_flow_ok_i,
	input  wire                 cool_press_ok_i,
	input  wire                 cool_temp_ok_i,
	input  wire                 cool_level_ok_i,
	input  wire                 service_clear_i,
	input  wire                 session_req_i,
	input  wire                 session_end_i,
	output reg                  session_start_o,
	output reg                  supply_active_o,
	output reg                  shutdown_o,
	output reg  [`TS_CUR_W-1:0]  cur_limit_o,
	output reg                  cur_report_o,
	output reg                  overtemp_o,
	output reg                  sensor_fault_o,
	output reg                  cool_fail_o,
	output reg                  lockout_o
);
	// ************************************************************
	// Input synchronisers
	// ************************************************************
	reg [`TS_TEMP_W-1:0] pos_m_q, pos_s_q, neg_m_q, neg_s_q;
	reg [1:0]            vld_m_q, vld_s_q, vld_p_q;
	reg [3:0]            cool_m_q, cool_s_q;
	reg                  svc_m_q, svc_s_q;

	always @(posedge clk_sys_i) begin
		pos_m_q  <= temp_pos_i;
		pos_s_q  <= pos_m_q;
		neg_m_q  <= temp_neg_i;
		neg_s_q  <= neg_m_q;
		vld_m_q  <= {temp_neg_valid_i, temp_pos_valid_i};
		vld_s_q  <= vld_m_q;
		vld_p_q  <= vld_s_q;
		cool_m_q <= {cool_level_ok_i, cool_temp_ok_i, cool_press_ok_i, cool_flow_ok_i};
		cool_s_q <= cool_m_q;
		svc_m_q  <= service_clear_i;
		svc_s_q  <= svc_m_q;
	end

	// ************************************************************
	// Per-contact evaluation
	// ************************************************************
	function over_limit;
		input [`TS_TEMP_W-1:0] t;
		begin
			over_limit = (t > `TS_LIMIT_CODE);
		end
	endfunction

	function implausible;
		input [`TS_TEMP_W-1:0] t;
		begin
			implausible = (t < `TS_PLAUS_MIN) || (t > `TS_PLAUS_MAX);
		end
	endfunction

	// A multi-bit word can tear through the synchroniser; the value is only taken
	// on a settled valid strobe edge, one cycle after valid has passed two stages.
	reg [`TS_TEMP_W-1:0] pos_q, neg_q;
	reg [31:0]           silent_pos_q, silent_neg_q;
	wire                 new_pos = vld_s_q[0] & ~vld_p_q[0];
	wire                 new_neg = vld_s_q[1] & ~vld_p_q[1];

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			pos_q        <= 10'h000;
			neg_q        <= 10'h000;
			silent_pos_q <= 32'h0;
			silent_neg_q <= 32'h0;
		end else begin
			if (new_pos) begin // R2
				pos_q        <= pos_s_q;
				silent_pos_q <= 32'h0;
			end else if (silent_pos_q < SILENT_CYC) begin
				silent_pos_q <= silent_pos_q + 32'h1;
			end
			if (new_neg) begin // R2
				neg_q        <= neg_s_q;
				silent_neg_q <= 32'h0;
			end else if (silent_neg_q < SILENT_CYC) begin
				silent_neg_q <= silent_neg_q + 32'h1;
			end
		end
	end

	wire pos_silent = (silent_pos_q >= SILENT_CYC);
	wire neg_silent = (silent_neg_q >= SILENT_CYC);
	wire sens_bad   = pos_silent | neg_silent | implausible(pos_q) | implausible(neg_q);
	wire hot_now    = over_limit(pos_q) | over_limit(neg_q); // R2
	wire cool_bad   = ~&cool_s_q; // R12

	// ************************************************************
	// Session control
	// ************************************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RUN  = 2'h1;
	localparam [1:0] ST_SHUT = 2'h2;

	reg [1:0] state_q;
	reg [1:0] ot_cnt_q;
	reg       ot_lock_q, plaus_lock_q, derate_q;
	wire      running = (state_q == ST_RUN);
	wire      hot_hit, sens_hit;

	// Filtering trades a short reaction delay for immunity to single glitches;
	// the filter stays far below the 9 s deadline.
	fault_filter #(.LIMIT(FILTER_CYC)) u_hot (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.fault_i   (hot_now & running), // R5
		.hit_o     (hot_hit)
	);

	fault_filter #(.LIMIT(FILTER_CYC)) u_sens (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.fault_i   (sens_bad & running), // R5
		.hit_o     (sens_hit)
	);

	wire cool_stop = cool_bad & (HAS_NOCOOL == 0); // R3
	wire locked    = ot_lock_q | plaus_lock_q;

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_q         <= ST_IDLE;
			ot_cnt_q        <= 2'h0;
			ot_lock_q       <= 1'b0;
			plaus_lock_q    <= 1'b0;
			derate_q        <= 1'b0;
			session_start_o <= 1'b0;
			shutdown_o      <= 1'b0;
		end else begin
			session_start_o <= 1'b0;
			shutdown_o      <= 1'b0;
			// The clear comes first so that a lockout raised in the same cycle wins;
			// an overtemperature event during service must never be lost.
			if (svc_s_q) begin // R13
				ot_lock_q    <= 1'b0;
				plaus_lock_q <= 1'b0;
				derate_q     <= 1'b0;
				ot_cnt_q     <= 2'h0;
			end
			case (state_q)
			ST_IDLE: begin
				if (session_req_i && !locked) begin
					if (sens_bad || hot_now) begin // R8
						plaus_lock_q <= 1'b1; // R10
						derate_q     <= 1'b1; // R9
					end else begin
						state_q         <= ST_RUN;
						session_start_o <= 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (hot_hit) begin // R6 R1
					shutdown_o <= 1'b1;
					state_q    <= ST_SHUT;
					if (ot_cnt_q == `TS_LOCK_COUNT - 2'h1) begin
						ot_lock_q <= 1'b1; // R7
					end
					ot_cnt_q <= ot_cnt_q + 2'h1; // R7
				end else if (sens_hit || cool_stop) begin // R11 R3
					shutdown_o <= 1'b1;
					state_q    <= ST_SHUT;
				end else if (session_end_i) begin
					ot_cnt_q <= 2'h0; // R13
					state_q  <= ST_IDLE;
				end
			end
			ST_SHUT: begin
				if (!session_req_i) begin
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// Current limit, vehicle report and status
	// ************************************************************
	wire [`TS_CUR_W-1:0] lim_d = (derate_q || cool_bad) ? NOCOOL_CUR : RATED_CUR; // R3 R9

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			cur_limit_o     <= RATED_CUR;
			cur_report_o    <= 1'b0;
			supply_active_o <= 1'b0;
			overtemp_o      <= 1'b0;
			sensor_fault_o  <= 1'b0;
			cool_fail_o     <= 1'b0;
			lockout_o       <= 1'b0;
		end else begin
			cur_limit_o     <= lim_d;
			cur_report_o    <= (lim_d != cur_limit_o); // R4
			supply_active_o <= running & ~hot_hit & ~sens_hit & ~cool_stop; // R1
			overtemp_o      <= hot_now; // R14
			sensor_fault_o  <= sens_bad | plaus_lock_q; // R14
			cool_fail_o     <= cool_bad; // R14
			lockout_o       <= locked; // R14
		end
	end
endmodule // connector_thermal_supervisor

/* File: connector_thermal_supervisor_assertions.sv */
// Port-level checker for the connector thermal supervisor, bound to its top module.
// Assumes the shortened filter and silence counts that the bench sets.
`timescale 1ns/1ps
`include "thermal_supervisor_map.vh"
module ts_port_checker #(
	parameter [`TS_CUR_W-1:0] NOCOOL_CUR = 10'h064
) (
	input logic                 clk_sys_i,
	input logic                 rst_i,
	input logic                 cool_flow_ok_i,
	input logic                 service_clear_i,
	input logic                 session_start_o,
	input logic                 supply_active_o,
	input logic                 shutdown_o,
	input logic [`TS_CUR_W-1:0] cur_limit_o,
	input logic                 cur_report_o,
	input logic                 overtemp_o,
	input logic                 sensor_fault_o,
	input logic                 cool_fail_o,
	input logic                 lockout_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// The clear input passes a synchroniser, so a lockout may fall a few cycles after it.
	logic [2:0] clr_age_q;
	always @(posedge clk_sys_i) begin
		clr_age_q <= (rst_i || service_clear_i) ? 3'h0 : clr_age_q + {2'h0, clr_age_q != 3'h7};
	end
	property p_run; session_start_o |=> supply_active_o; endproperty
	a_run: assert property (p_run) else $error("supply not active after start");
	property p_drop; shutdown_o |-> !supply_active_o; endproperty
	a_drop: assert property (p_drop) else $error("supply still active at shutdown");
	property p_once; shutdown_o |=> !shutdown_o; endproperty
	a_once: assert property (p_once) else $error("shutdown pulse too long");
	property p_cause; shutdown_o |-> overtemp_o || sensor_fault_o; endproperty
	a_cause: assert property (p_cause) else $error("shutdown without flag");
	property p_refuse; $past(lockout_o) && lockout_o |-> !session_start_o; endproperty
	a_refuse: assert property (p_refuse) else $error("start while locked");
	property p_derate; cool_fail_o |-> cur_limit_o == NOCOOL_CUR; endproperty
	a_derate: assert property (p_derate) else $error("no derate on cooling fault");
	property p_report; $changed(cur_limit_o) |-> ##[0:1] cur_report_o; endproperty
	a_report: assert property (p_report) else $error("limit change not reported");
	property p_cool; (!cool_flow_ok_i)[*8] |-> ##[0:12] cool_fail_o; endproperty
	a_cool: assert property (p_cool) else $error("flow loss not flagged");
	property p_hold; $fell(lockout_o) |-> clr_age_q < 3'h6; endproperty
	a_hold: assert property (p_hold) else $error("lockout left without clear");
endmodule // ts_port_checker

bind connector_thermal_supervisor ts_port_checker #(.NOCOOL_CUR(NOCOOL_CUR)) u_chk (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cool_flow_ok_i(cool_flow_ok_i),
	.service_clear_i(service_clear_i), .session_start_o(session_start_o),
	.supply_active_o(supply_active_o), .shutdown_o(shutdown_o), .cur_limit_o(cur_limit_o),
	.cur_report_o(cur_report_o), .overtemp_o(overtemp_o), .sensor_fault_o(sensor_fault_o),
	.cool_fail_o(cool_fail_o), .lockout_o(lockout_o));

/* File: contact_sensor_model.sv */
// Behavioural pair of contact temperature sensors, one strobe every eight cycles.
// Assumes codes come from the bench; silent_i withholds strobes like a dead sensor.
`timescale 1ns/1ps
`include "thermal_supervisor_map.vh"
module contact_sensor_model (
	input  wire                  clk_i,
	input  wire                  silent_i,
	input  wire [`TS_TEMP_W-1:0] pos_code_i,
	input  wire [`TS_TEMP_W-1:0] neg_code_i,
	output reg  [`TS_TEMP_W-1:0] pos_o = 10'h000,
	output reg  [`TS_TEMP_W-1:0] neg_o = 10'h000,
	output reg                   pos_valid_o = 1'b0,
	output reg                   neg_valid_o = 1'b0
);
	reg [2:0] cnt_q = 3'h0;
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 3'h1;
		// Codes change only with both strobes low, so no capture sees a torn value.
		if (cnt_q == 3'h0) begin
			pos_o <= pos_code_i;
			neg_o <= neg_code_i;
		end
		pos_valid_o <= !silent_i && cnt_q >= 3'h2 && cnt_q < 3'h5;
		neg_valid_o <= !silent_i && cnt_q >= 3'h2 && cnt_q < 3'h5;
	end
endmodule // contact_sensor_model

/* File: test_connector_thermal_supervisor.sv */
// Self-checking bench for the connector thermal supervisor with a sensor model.
// Assumes short filter and silence counts; notes of expected pulses sit in a queue.
`timescale 1ns/1ps
`include "thermal_supervisor_map.vh"
module test_connector_thermal_supervisor;
	logic                  clk_sys_i = 0, rst_i = 1, req = 0, s_end = 0, clr = 0, silent = 0;
	logic [3:0]            cool = 4'hF;
	logic [`TS_TEMP_W-1:0] pos = 10'h050, neg = 10'h050;
	wire  [`TS_TEMP_W-1:0] tp, tn;
	wire  [`TS_CUR_W-1:0]  lim;
	wire                   vp, vn, st, sa, sd, rep, ot, sf, cf, lk;
	logic [4:0]            notes[$];
	int                    error_cnt = 0, n_compared = 0;
	connector_thermal_supervisor #(.FILTER_CYC(4), .SILENT_CYC(50)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .temp_pos_i(tp), .temp_pos_valid_i(vp),
		.temp_neg_i(tn), .temp_neg_valid_i(vn), .cool_flow_ok_i(cool[0]),
		.cool_press_ok_i(cool[1]), .cool_temp_ok_i(cool[2]), .cool_level_ok_i(cool[3]),
		.service_clear_i(clr), .session_req_i(req), .session_end_i(s_end),
		.session_start_o(st), .supply_active_o(sa), .shutdown_o(sd), .cur_limit_o(lim),
		.cur_report_o(rep), .overtemp_o(ot), .sensor_fault_o(sf), .cool_fail_o(cf),
		.lockout_o(lk));
	contact_sensor_model u_sens (.clk_i(clk_sys_i), .silent_i(silent), .pos_code_i(pos),
		.neg_code_i(neg), .pos_o(tp), .neg_o(tn), .pos_valid_o(vp), .neg_valid_o(vn));
	initial forever #25 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [9:0] a, input logic [9:0] e);
		n_compared++;
		if (a !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// Waits a bounded time for all noted pulses to appear.
	task automatic drain(input int n);
		int k;
		k = 0;
		while (notes.size() != 0 && k < n) begin
			cyc(1);
			k++;
		end
		chk(10'(notes.size()), 10'h000);
	endtask
	task automatic start();
		notes.push_back(5'b10000);
		req = 1;
		drain(10);
	endtask
	task automatic clear();
		clr = 1;
		cyc(4);
		clr = 0;
		cyc(8);
	endtask
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Any pulse with no matching note is a mismatch.
	always @(negedge clk_sys_i) begin
		logic [4:0] e;
		if (!rst_i && (st || sd || rep)) begin
			e = (notes.size() != 0) ? notes.pop_front() : 5'b00000;
			n_compared++;
			if ({st, sd, rep} !== e[4:2] || (e[1] && ot !== 1'b1) || (e[0] && sf !== 1'b1)) begin
				error_cnt++;
				$display("mismatch at %0t: pulse %b%b%b not expected", $time, st, sd, rep);
			end
		end
	end
	initial begin
		#(50 * 20000);
		error_cnt++;
		$display("mismatch at %0t: run hung", $time);
		give_verdict();
	end
	initial begin
		void'($urandom(88));
		cyc(8);
		rst_i = 0;
		cyc(20);
		pos = 10'h0B4;
		neg = 10'($urandom % 181);
		start();
		cyc(40);
		chk(sa, 10'h001);
		req = 0;
		s_end = 1;
		cyc(1);
		s_end = 0;
		cyc(8);
		$display("test limit done");
		for (int i = 0; i < 3; i++) begin
			start();
			notes.push_back(5'b01010);
			if (i[0]) neg = 10'h0B5;
			else pos = 10'h0B5;
			drain(40);
			req = 0;
			pos = 10'($urandom % 181);
			neg = 10'h050;
			cyc(20);
		end
		chk(lk, 10'h001);
		req = 1;
		cyc(20);
		req = 0;
		clear();
		chk(lk, 10'h000);
		$display("test lockout done");
		start();
		notes.push_back(5'b01001);
		silent = 1;
		drain(150);
		req = 0;
		silent = 0;
		cyc(20);
		clear();
		$display("test silence done");
		neg = 10'h191 + 10'($urandom % 623);
		cyc(20);
		notes.push_back(5'b00100);
		req = 1;
		drain(20);
		req = 0;
		chk(lim, 10'h064);
		chk(lk, 10'h001);
		notes.push_back(5'b00100);
		neg = 10'h050;
		clear();
		drain(20);
		chk(lim, 10'h1F4);
		$display("test plausibility done");
		for (int b = 0; b < 4; b++) begin
			notes.push_back(5'b00100);
			cool = ~(4'($urandom) | (4'h1 << b));
			drain(40);
			chk(cf, 10'h001);
			chk(lim, 10'h064);
			cyc(10);
			notes.push_back(5'b00100);
			cool = 4'hF;
			drain(40);
			chk(cf, 10'h000);
		end
		$display("test cooling done");
		give_verdict();
	end
endmodule // test_connector_thermal_supervisor
